// ---- src/rpdr_pkg.sv ----
// Package of constants for the power defaults and test/reset pin block
package rpdr_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_HZ          = 200_000_000; // System clock rate
   localparam int TEST_FREQ_HZ    = 512;         // Test square wave rate
   localparam int TEST_HALF_CYC   = CLK_HZ / (2 * TEST_FREQ_HZ); // Half period
   localparam int CAL_XFER_MS     = 8;           // Factory value transfer time
   localparam int CAL_XFER_CYC    = (CLK_HZ / 1000) * CAL_XFER_MS; // In cycles

   // ****************************************************************
   // Register offsets (byte addresses on the plain port)
   // ****************************************************************
   localparam logic [7:0] ADDR_DCAL   = 8'h08; // Output level, freq test, digital cal
   localparam logic [7:0] ADDR_WDOG   = 8'h09; // Osc fail irq enable, watchdog
   localparam logic [7:0] ADDR_ALM1   = 8'h0a; // Alarm 1 enables
   localparam logic [7:0] ADDR_ACAL   = 8'h12; // Analog calibration
   localparam logic [7:0] ADDR_CTRL   = 8'h20; // Lock and misc control bits
   localparam logic [7:0] ADDR_TIMER  = 8'h21; // Timer and rate bits
   localparam logic [7:0] ADDR_ALM2   = 8'h22; // Alarm 2 bits
   localparam logic [7:0] ADDR_STAT   = 8'h23; // Block status

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int DCAL_OUT_BIT  = 7; // Output level bit
   localparam int DCAL_FT_BIT   = 6; // Frequency test bit
   localparam int DCAL_SIGN_BIT = 5; // Digital cal sign
   localparam int WDOG_OSC_FAIL_IRQ_ENABLE_BIT = 7; // Osc fail irq enable
   localparam int ALM1_IE_BIT   = 7; // Alarm 1 irq enable
   localparam int ALM1_SQUARE_WAVE_ENABLE_BIT = 6; // Square wave enable
   localparam int ALM1_ABE_BIT  = 5; // Alarm in backup enable
   localparam int CTRL_LOCK_BIT = 0; // Calibration lock
   localparam int CTRL_ST_BIT   = 1; // Oscillator stop
   localparam int CTRL_CBL_BIT  = 2; // Century low
   localparam int CTRL_CBH_BIT  = 3; // Century high
   localparam int CTRL_HT_BIT   = 4; // Halt update
   localparam int CTRL_OF_BIT   = 5; // Oscillator fail flag
   localparam int CTRL_ACS_BIT  = 6; // Analog cal sign

   // ****************************************************************
   // Initial power-up values
   // ****************************************************************
   localparam logic [7:0] DCAL_INIT  = 8'h80; // Output level 1, all else 0
   localparam logic [7:0] WDOG_INIT  = 8'h00; // Irq enable, multiplier, resolution 0
   localparam logic [7:0] ALM1_INIT  = 8'h40; // Square wave enable 1
   localparam logic [7:0] ACAL_INIT  = 8'h00; // Analog cal 0
   localparam logic [7:0] CTRL_INIT  = 8'h30; // Halt update and osc fail set
   localparam logic [7:0] TIMER_INIT = 8'h1c; // Timer freq 11, rate lo 1
   localparam logic [7:0] ALM2_INIT  = 8'h00; // Alarm 2 cleared
   localparam logic [7:0] WDOG_KEEP  = 8'h80; // Bits kept on later power-up
   localparam logic [7:0] TIMER_TE   = 8'h80; // Timer enable bit mask
   localparam logic [7:0] ACAL_FACTORY = 8'h5a; // Arbitrary factory cal default
endpackage : rpdr_pkg

// ---- src/rpdr_half_div.sv ----
// Divider producing the toggle enable for the test square wave
`timescale 1ns/1ps
module rpdr_half_div
   import rpdr_pkg::*;
#(
   parameter int HALF_CYC = TEST_HALF_CYC // Cycles per half period
)(
   input  wire logic clk_i,   // System clock
   input  wire logic rst_i,   // Async reset
   input  wire logic run_i,   // Count while high
   output logic      tick_o   // One-cycle toggle enable
);
   // ****************************************************************
   // Counter
   // ****************************************************************
   logic [31:0] cnt_reg; // Cycle count in half period

   // Restart from zero whenever stopped, so each run starts in phase
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_reg <= 32'h0;
         tick_o  <= 1'b0;
      end
      else if (!run_i)
      begin
         cnt_reg <= 32'h0;
         tick_o  <= 1'b0;
      end
      else if (cnt_reg == 32'(HALF_CYC - 1))
      begin
         cnt_reg <= 32'h0;
         tick_o  <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 32'h1;
         tick_o  <= 1'b0;
      end
   end
endmodule : rpdr_half_div

// ---- src/rpdr_top.sv ----
// Power defaults, calibration lock and shared test/reset pin logic
//
// Operation
// - Test bit high drives 512 Hz wave
// - Test bit low, supply good: pin high
// - Supply fail clears test bit, asserts reset
// - Every power-up forces test bit low
// - First power-up loads part one defaults
// - First power-up loads part two defaults
// - Backed power-up keeps bits, forces few
// - Lock set copies factory value, read-only
// - Lock clear makes calibration plain storage
// - Factory transfer takes about 8 ms
`timescale 1ns/1ps
module rpdr_top
   import rpdr_pkg::*;
#(
   parameter int XFER_CYC = CAL_XFER_CYC // Transfer time, shorten in sim
)(
   input  wire logic       CLK_I,         // 200 MHz clock
   input  wire logic       RST_I,         // Async reset, high
   input  wire logic       SUPPLY_GOOD_I, // Supply above reset threshold
   input  wire logic       BACKUP_VALID_I,// Battery kept registers alive
   input  wire logic [7:0] FACTORY_CAL_I, // Factory programmed cal value
   input  wire logic [7:0] ADDR_I,        // Register address
   input  wire logic [7:0] WDATA_I,       // Write data
   input  wire logic       WR_I,          // Write strobe
   input  wire logic       RD_I,          // Read strobe
   output logic      [7:0] RDATA_O,       // Read data, one cycle later
   output logic            TEST_RESET_PIN_O,  // Open-drain output level
   output logic            TEST_RESET_PIN_OE_O, // Low while pulling pin low
   output logic            CAL_BUSY_O     // Factory transfer in progress
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   typedef enum logic [1:0] {RPDR_OFF, RPDR_PWRUP, RPDR_RUN} rpdr_pwr_e;

   rpdr_pwr_e   pwr_reg;        // Power sequencing state
   logic        first_done_reg; // Registers hold valid contents
   logic [7:0]  dcal_reg;       // Output, test, digital cal
   logic [7:0]  wdog_reg;       // Osc fail enable, watchdog
   logic [7:0]  alm1_reg;       // Alarm 1 enables and repeat
   logic [7:0]  acal_reg;       // Analog calibration
   logic [7:0]  ctrl_reg;       // Lock and misc control
   logic [7:0]  timer_reg;      // Timer, rate select
   logic [7:0]  alm2_reg;       // Alarm 2 bits
   logic [31:0] xfer_cnt_reg;   // Factory transfer counter
   logic        xfer_reg;       // Transfer running
   logic        sq_reg;         // Square wave level
   logic        tick;           // Half period enable
   logic        pwr_up;         // One-cycle power-up event
   logic        pwr_fail;       // Supply lost while running
   logic        wr_ok;          // Write accepted while powered

   assign pwr_up   = (pwr_reg == RPDR_PWRUP);
   assign pwr_fail = (pwr_reg == RPDR_RUN) && !SUPPLY_GOOD_I;
   assign wr_ok    = WR_I && (pwr_reg == RPDR_RUN) && SUPPLY_GOOD_I;

   // ****************************************************************
   // Power sequencing
   // ****************************************************************
   // Off until supply good, one power-up cycle, then running
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         pwr_reg <= RPDR_OFF;
      end
      else
      begin
         case (pwr_reg)
            RPDR_OFF:   if (SUPPLY_GOOD_I) pwr_reg <= RPDR_PWRUP;
            RPDR_PWRUP: pwr_reg <= SUPPLY_GOOD_I ? RPDR_RUN : RPDR_OFF;
            RPDR_RUN:   if (!SUPPLY_GOOD_I) pwr_reg <= RPDR_OFF;
            default:    pwr_reg <= RPDR_OFF;
         endcase
      end
   end

   // Contents are trusted only if a backed power-up follows a good one
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         first_done_reg <= 1'b0;
      else if (pwr_up)
         first_done_reg <= 1'b1;
      else if (pwr_reg == RPDR_OFF && !BACKUP_VALID_I)
         first_done_reg <= 1'b0; // Backup lost: next power-up is initial
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   // Output and frequency test register
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         dcal_reg <= DCAL_INIT;
      else if (pwr_up && !(first_done_reg && BACKUP_VALID_I))
         dcal_reg <= DCAL_INIT;
      else if (pwr_up)
         dcal_reg[DCAL_FT_BIT] <= 1'b0;
      else if (pwr_fail)
         dcal_reg[DCAL_FT_BIT] <= 1'b0;
      else if (wr_ok && ADDR_I == ADDR_DCAL)
         dcal_reg <= WDATA_I;
   end

   // Watchdog register: multiplier and resolution always cleared at power-up
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         wdog_reg <= WDOG_INIT;
      else if (pwr_up && !(first_done_reg && BACKUP_VALID_I))
         wdog_reg <= WDOG_INIT;
      else if (pwr_up)
         wdog_reg <= wdog_reg & WDOG_KEEP;
      else if (wr_ok && ADDR_I == ADDR_WDOG)
         wdog_reg <= WDATA_I;
   end

   // Alarm 1 and alarm 2 enables, kept on backed power-up
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         alm1_reg <= ALM1_INIT;
         alm2_reg <= ALM2_INIT;
      end
      else if (pwr_up && !(first_done_reg && BACKUP_VALID_I))
      begin
         alm1_reg <= ALM1_INIT;
         alm2_reg <= ALM2_INIT;
      end
      else if (wr_ok && ADDR_I == ADDR_ALM1)
         alm1_reg <= WDATA_I;
      else if (wr_ok && ADDR_I == ADDR_ALM2)
         alm2_reg <= WDATA_I;
   end

   // Timer register: timer enable always cleared at power-up
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         timer_reg <= TIMER_INIT;
      else if (pwr_up && !(first_done_reg && BACKUP_VALID_I))
         timer_reg <= TIMER_INIT;
      else if (pwr_up)
         timer_reg <= timer_reg & ~TIMER_TE;
      else if (wr_ok && ADDR_I == ADDR_TIMER)
         timer_reg <= WDATA_I;
   end

   // Control register: halt update always set at power-up
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         ctrl_reg <= CTRL_INIT;
      else if (pwr_up && !(first_done_reg && BACKUP_VALID_I))
         ctrl_reg <= CTRL_INIT;
      else if (pwr_up)
         ctrl_reg[CTRL_HT_BIT] <= 1'b1;
      else if (wr_ok && ADDR_I == ADDR_CTRL)
         ctrl_reg <= WDATA_I;
   end

   // ****************************************************************
   // Calibration lock and factory transfer
   // ****************************************************************
   // Rising lock starts the timed transfer; clearing lock aborts it
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         xfer_reg     <= 1'b0;
         xfer_cnt_reg <= 32'h0;
      end
      else if (pwr_up)
      begin
         xfer_reg     <= 1'b0;
         xfer_cnt_reg <= 32'h0;
      end
      // Start must be tested before the abort: lock still reads 0 here
      else if (wr_ok && ADDR_I == ADDR_CTRL && WDATA_I[CTRL_LOCK_BIT]
               && !ctrl_reg[CTRL_LOCK_BIT])
      begin
         xfer_reg     <= 1'b1;
         xfer_cnt_reg <= 32'h0;
      end
      else if (!ctrl_reg[CTRL_LOCK_BIT])
      begin
         xfer_reg     <= 1'b0;
         xfer_cnt_reg <= 32'h0;
      end
      else if (xfer_reg)
      begin
         if (xfer_cnt_reg == 32'(XFER_CYC - 1))
            xfer_reg <= 1'b0;
         xfer_cnt_reg <= xfer_cnt_reg + 32'h1;
      end
   end

   // Analog cal: user storage when unlocked, factory copy when locked
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         acal_reg <= ACAL_INIT;
      else if (pwr_up && !(first_done_reg && BACKUP_VALID_I))
         acal_reg <= ACAL_INIT;
      else if (xfer_reg && xfer_cnt_reg == 32'(XFER_CYC - 1))
         acal_reg <= FACTORY_CAL_I;
      else if (wr_ok && ADDR_I == ADDR_ACAL && !ctrl_reg[CTRL_LOCK_BIT])
         acal_reg <= WDATA_I;
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   // Read data stands one cycle after the strobe; unmapped reads zero
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         RDATA_O <= 8'h00;
      else if (RD_I)
      begin
         case (ADDR_I)
            ADDR_DCAL:  RDATA_O <= dcal_reg;
            ADDR_WDOG:  RDATA_O <= wdog_reg;
            ADDR_ALM1:  RDATA_O <= alm1_reg;
            ADDR_ACAL:  RDATA_O <= acal_reg;
            ADDR_CTRL:  RDATA_O <= ctrl_reg;
            ADDR_TIMER: RDATA_O <= timer_reg;
            ADDR_ALM2:  RDATA_O <= alm2_reg;
            ADDR_STAT:  RDATA_O <= {5'h00, xfer_reg, first_done_reg,
                                    (pwr_reg == RPDR_RUN)};
            default:    RDATA_O <= 8'h00;
         endcase
      end
      else
         RDATA_O <= 8'h00;
   end

   // ****************************************************************
   // Test square wave and pin
   // ****************************************************************
   rpdr_half_div #(
      .HALF_CYC (TEST_HALF_CYC)
   ) u_div (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .run_i  (dcal_reg[DCAL_FT_BIT] && pwr_reg == RPDR_RUN),
      .tick_o (tick)
   );

   // Square wave toggles on each half period, idles high
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         sq_reg <= 1'b1;
      else if (!dcal_reg[DCAL_FT_BIT])
         sq_reg <= 1'b1;
      else if (tick)
         sq_reg <= ~sq_reg;
   end

   // Open drain: enable low pulls the pin low, high releases it
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         TEST_RESET_PIN_O    <= 1'b0;
         TEST_RESET_PIN_OE_O <= 1'b0;
      end
      else if (!SUPPLY_GOOD_I || pwr_reg != RPDR_RUN)
      begin
         TEST_RESET_PIN_O    <= 1'b0;
         TEST_RESET_PIN_OE_O <= 1'b0;
      end
      else if (dcal_reg[DCAL_FT_BIT])
      begin
         TEST_RESET_PIN_O    <= sq_reg;
         TEST_RESET_PIN_OE_O <= sq_reg;
      end
      else
      begin
         TEST_RESET_PIN_O    <= 1'b1;
         TEST_RESET_PIN_OE_O <= 1'b1;
      end
   end

   // Busy flag mirrors the transfer so software can wait it out
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         CAL_BUSY_O <= 1'b0;
      else
         CAL_BUSY_O <= xfer_reg;
   end
endmodule : rpdr_top

// ---- sim/rpdr_host_model.sv ----
// Host reset input model on the shared open-drain pin
`timescale 1ns/1ps
module rpdr_host_model (
   input  wire logic clk_i,        // System clock
   input  wire logic pin_o_i,      // Pin level from the block
   input  wire logic pin_oe_i,     // Low while the block pulls low
   output logic      host_rst_n_o, // Resolved pin, host reset low
   output int        rise_cnt_o    // Releases seen by the host
);
   // ****
   // Wire and edge counter
   // ****
   logic last_q = 1'b0; // Previous resolved level
   int   rise_cnt = 0;  // Release counter
   // Released line floats to the pull-up, never to the last value
   assign host_rst_n_o = pin_oe_i ? 1'b1 : pin_o_i;
   // Count host reset releases
   always @(posedge clk_i)
   begin
      last_q <= host_rst_n_o;
      if (host_rst_n_o && !last_q)
         rise_cnt <= rise_cnt + 1;
   end
   assign rise_cnt_o = rise_cnt;
endmodule : rpdr_host_model

// ---- sim/rpdr_chk_assertions.sv ----
// Assertion checker for the power defaults block
`timescale 1ns/1ps
module rpdr_chk
   import rpdr_pkg::*;
#(
   parameter int XFER_CYC = 20 // Transfer time in cycles
)(
   input wire logic       CLK_I,
   input wire logic       RST_I,
   input wire logic       SUPPLY_GOOD_I,
   input wire logic       BACKUP_VALID_I,
   input wire logic [7:0] FACTORY_CAL_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic       WR_I,
   input wire logic       RD_I,
   input wire logic [7:0] RDATA_O,
   input wire logic       TEST_RESET_PIN_O,
   input wire logic       TEST_RESET_PIN_OE_O,
   input wire logic       CAL_BUSY_O
);
   // ****
   // Helper counters
   // ****
   int busy_cnt; // Consecutive busy cycles
   int hi_cnt;   // Consecutive pin high cycles
   // Counters restart when their signal drops
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         busy_cnt <= 0;
         hi_cnt   <= 0;
      end
      else
      begin
         busy_cnt <= CAL_BUSY_O ? busy_cnt + 1 : 0;
         hi_cnt   <= TEST_RESET_PIN_O ? hi_cnt + 1 : 0;
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   pin_low_fail_a: assert property (!SUPPLY_GOOD_I |=> !TEST_RESET_PIN_O)
      else $error("pin high while supply bad");
   pin_oe_match_a: assert property (TEST_RESET_PIN_O == TEST_RESET_PIN_OE_O)
      else $error("pin level and enable differ");
   powerup_high_a: assert property ($rose(SUPPLY_GOOD_I) |-> ##[1:4] TEST_RESET_PIN_O)
      else $error("pin not released after power-up");
   wave_half_a: assert property (($fell(TEST_RESET_PIN_O) && SUPPLY_GOOD_I
      && $past(SUPPLY_GOOD_I)) |-> $past(hi_cnt) >= TEST_HALF_CYC - 2)
      else $error("test wave half period too short");
   rdata_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data without read");
   unmapped_read_a: assert property (RD_I && ADDR_I == 8'h30 |=> RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   busy_len_a: assert property (busy_cnt <= XFER_CYC + 1)
      else $error("transfer runs too long");
   busy_cause_a: assert property ($rose(CAL_BUSY_O) |-> $past(WR_I) || $past(WR_I, 2))
      else $error("transfer without write");
   busy_c: cover property ($fell(CAL_BUSY_O));
   fail_c: cover property ($fell(SUPPLY_GOOD_I) ##1 !TEST_RESET_PIN_O);
   read_c: cover property (RD_I ##1 RDATA_O != 8'h00);
endmodule : rpdr_chk
bind rpdr_top rpdr_chk #(.XFER_CYC(XFER_CYC)) chk_u (.CLK_I(CLK_I), .RST_I(RST_I),
   .SUPPLY_GOOD_I(SUPPLY_GOOD_I), .BACKUP_VALID_I(BACKUP_VALID_I),
   .FACTORY_CAL_I(FACTORY_CAL_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
   .RD_I(RD_I), .RDATA_O(RDATA_O), .TEST_RESET_PIN_O(TEST_RESET_PIN_O),
   .TEST_RESET_PIN_OE_O(TEST_RESET_PIN_OE_O), .CAL_BUSY_O(CAL_BUSY_O));

// ---- sim/rtc_power_defaults_reset_pin_tb.sv ----
// Self-checking bench for the power defaults block
`timescale 1ns/1ps
module rtc_power_defaults_reset_pin_tb
   import rpdr_pkg::*;
;
   // ****
   // Stimulus and tables
   // ****
   localparam int XFER = 20; // Shortened transfer time
   localparam logic [7:0] RA [7] = '{8'h08, 8'h09, 8'h0a, 8'h12, 8'h20, 8'h21, 8'h22};
   localparam logic [7:0] INI[7] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h30, 8'h1c, 8'h00};
   localparam logic [7:0] WV [7] = '{8'he5, 8'hff, 8'ha0, 8'h33, 8'h4e, 8'h9c, 8'h07};
   localparam logic [7:0] KPT[7] = '{8'ha5, 8'h80, 8'ha0, 8'h33, 8'h5e, 8'h1c, 8'h07};
   logic       clk  = 1'b0;  // 200 MHz clock
   logic       rst  = 1'b1;  // Reset, high
   logic       sup  = 1'b0;  // Supply good
   logic       bkp  = 1'b0;  // Battery held contents
   logic [7:0] fcal = 8'hc3; // Factory value, arbitrary
   logic [7:0] addr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic       wr   = 1'b0;
   logic       rd   = 1'b0;
   logic [7:0] rdat;
   logic       pin_o;
   logic       pin_oe;
   logic       busy;
   logic       host_n;       // Host reset, low active
   int         host_rises;   // Releases seen by the host
   int         err_total = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   always #2.5 clk = ~clk;
   rpdr_top #(.XFER_CYC(XFER)) dut_u (.CLK_I(clk), .RST_I(rst), .SUPPLY_GOOD_I(sup),
      .BACKUP_VALID_I(bkp), .FACTORY_CAL_I(fcal), .ADDR_I(addr), .WDATA_I(wdat),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .TEST_RESET_PIN_O(pin_o),
      .TEST_RESET_PIN_OE_O(pin_oe), .CAL_BUSY_O(busy));
   rpdr_host_model host_u (.clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
      .host_rst_n_o(host_n), .rise_cnt_o(host_rises));
   // ****
   // Shared tasks
   // ****
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   // Write then a gap edge, so strobes never reassign in one step
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdat <= d;
      wr   <= 1'b1;
      @(posedge clk);
      wr   <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 check(rdat, exp);
      @(posedge clk);
   endtask : rd_chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // ****
   // Scenarios
   // ****
   task automatic first_powerup;
      sup <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check({7'h0, host_n}, 8'h01);
      check({7'h0, host_rises == 1}, 8'h01);
      for (int i = 0; i < 7; i++)
         rd_chk(RA[i], INI[i]);
      rd_chk(8'h30, 8'h00);
   endtask : first_powerup
   // Full 512 Hz period exceeds the run, so only the high start is seen
   task automatic backed_powerup;
      for (int i = 0; i < 7; i++)
         wr_reg(RA[i], WV[i]);
      repeat (1000) @(posedge clk);
      #1 check({7'h0, host_n}, 8'h01);
      rd_chk(8'h08, 8'he5);
      bkp <= 1'b1; // Battery must hold by the time the supply drops
      sup <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({6'h0, host_n, pin_oe}, 8'h00);
      repeat (10) @(posedge clk);
      #1 check({7'h0, host_n}, 8'h00);
      sup <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check({7'h0, host_n}, 8'h01);
      for (int i = 0; i < 7; i++)
         rd_chk(RA[i], KPT[i]);
   endtask : backed_powerup
   task automatic cal_lock;
      int n;
      n = 0;
      wr_reg(8'h12, 8'h3c);
      rd_chk(8'h12, 8'h3c);
      wr_reg(8'h20, 8'h01);
      while (busy !== 1'b1 && n < 5)
      begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (busy === 1'b1 && n < XFER + 10)
      begin
         @(negedge clk);
         n++;
      end
      check({7'h0, n >= XFER - 1 && n <= XFER + 1}, 8'h01);
      @(posedge clk);
      rd_chk(8'h12, fcal);
      wr_reg(8'h12, 8'h11);
      rd_chk(8'h12, fcal);
      wr_reg(8'h20, 8'h00);
      wr_reg(8'h12, 8'h11);
      rd_chk(8'h12, 8'h11);
   endtask : cal_lock
   // ****
   // Main sequence and timeout
   // ****
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      first_powerup();
      backed_powerup();
      cal_lock();
      end_of_test();
   end
   // Run needs some 1120 cycles; the ceiling leaves wide margin
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         end_of_test();
      end
   end
endmodule : rtc_power_defaults_reset_pin_tb
